// ---- hdl/spi_eeprom_pkg.sv ----
// Notes on behaviour
// RULE_01: Device is slave; serial clock only input.
// RULE_02: All bytes shift most significant bit first.
// RULE_03: First eight bits after select form opcode.
// RULE_04: Unknown opcode: ignore input, output stays off.
// RULE_05: Deselected: ignore data input, output off.
// RULE_06: Pause asserted with clock low freezes sequence.
// RULE_07: Pause release resumes; paused clock edges ignored.
// RULE_08: While paused: output off, data input ignored.
// RULE_09: Guard pin low, guard enabled: refuse status writes.
// RULE_10: Guard falling during select aborts status write.
// RULE_11: Guard enable clear: guard pin fully ignored.
// RULE_12: Decode latch set, latch clear, status read.
// RULE_13: Decode status write, array read, array write.
// RULE_14: Latch starts clear; set it before programming.
// RULE_15: Latch clear works whatever the guard pin.
// RULE_16: Status bit 0 shows write cycle busy.
// RULE_17: Bit 1 latch, bits 3:2 level, 7 guard.
// RULE_18: Status bits 6:4 read zero when idle.
// RULE_19: Status reads all ones while write runs.
// RULE_20: Protect level selects read-only address range.
// RULE_21: Level and guard bits written by timed cycle.
// RULE_22: Hardware protect blocks status, protected blocks only.
// RULE_23: Guard enable cannot clear under hardware protect.
// RULE_24: During write cycle only status read accepted.
// RULE_25: Write cycle end clears the write latch.
// RULE_26: Sample on rising clock, shift out falling.
// RULE_27: Select rising ends command, output off, restart.
package spi_eeprom_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 50_000_000; // Core clock rate
  localparam int WRITE_TIME_US = 5000; // Longest self-timed write, microseconds
  // Longest time rounds down to whole cycles
  localparam int WRITE_CYCLES = (WRITE_TIME_US * (CLK_HZ / 1_000_000));

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes, bit 3 masked off as don't-care
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_LATCH_SET = 8'h06; // latch_set_cmd
  localparam logic [7:0] OP_LATCH_CLEAR = 8'h04; // latch_clear_cmd
  localparam logic [7:0] OP_STATUS_READ = 8'h05; // status_read_cmd
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01; // status_write_cmd
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // protection_status layout
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_LEVEL_LO_BIT = 2; // protect_level_low
  localparam int STAT_LEVEL_HI_BIT = 3; // protect_level_high
  localparam int STAT_GUARD_BIT = 7; // guard_pin_enable
  localparam logic [7:0] STAT_BUSY_VALUE = 8'hFF; // Shown during a write cycle

  ////////////////////////////////////////////////////////////////////////////
  // Address space
  localparam int ADDR_BITS = 17;
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2; // Three address bytes
  localparam logic [16:0] QUARTER_BASE = 17'h18000;
  localparam logic [16:0] HALF_BASE = 17'h10000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WRDATA = 3'b010,
    ST_STATUS_OUT = 3'b011,
    ST_STATUS_IN = 3'b100,
    ST_DATA_OUT = 3'b101,
    ST_IGNORE = 3'b110
  } cmd_state_t;

  typedef struct packed {
    logic csN; // Chip select, low active
    logic sck; // Serial clock
    logic si; // Serial data in
    logic holdN; // Pause, low active
    logic guardN; // Write-guard pin, low active
  } pin_in_t;

  typedef struct packed {
    logic guardEnable; // guard_pin_enable
    logic [1:0] level; // protect_level_high, protect_level_low
  } nv_status_t;

  localparam pin_in_t PINS_IDLE = 5'h17; // csN=1, sck=0, si=1, holdN=1, guardN=1
  localparam nv_status_t NV_RESET = 3'h0; // Stored bits after reset

endpackage

// ---- hdl/spi_eeprom_command_protect.sv ----
`timescale 1ns/1ps
module spi_eeprom_command_protect #(
  parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES // Write cycle length
)(
  input wire logic ref_clk, // Core clock
  input wire logic srst, // Synchronous reset, high
  input wire logic csN, // Chip select pin, low active
  input wire logic sck, // Serial clock pin from master
  input wire logic si, // Serial data in pin
  input wire logic holdN, // Pause pin, low active
  input wire logic guardN, // Write-guard pin, low active
  output logic soOut, // Serial data out level
  output logic soOe, // Serial data out enable, high drives
  output logic busy, // Internal write cycle running
  output logic writeLatch, // Write enable latch
  output logic [16:0] arrayAddr, // Array address pointer
  input wire logic [7:0] arrayRdData, // Array byte at arrayAddr
  output logic [7:0] arrayWrData, // Received write data byte
  output logic arrayWrStrobe, // Pulse: arrayWrData valid at arrayAddr
  output logic arrayWriteGo // Pulse: array write cycle starts
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    spi_eeprom_pkg::pin_in_t meta; // First synchroniser stage
    spi_eeprom_pkg::pin_in_t sync; // Second synchroniser stage
    logic sckPrev; // Last sampled serial clock
    logic csPrev; // Last sampled chip select
    spi_eeprom_pkg::cmd_state_t state; // Command parser state
    logic [2:0] bitCnt; // Bits of current byte
    logic [7:0] rxShift; // Receive shifter
    logic [1:0] addrCnt; // Address bytes taken
    logic isWrite; // Array command is a write
    logic [16:0] addr; // Array pointer
    logic [7:0] txShift; // Transmit shifter
    logic soOut; // Output bit
    logic soOe; // Output enable
    logic txLive; // A byte is being shifted out
    logic latch; // Write enable latch
    spi_eeprom_pkg::nv_status_t nv; // Stored protection bits
    spi_eeprom_pkg::nv_status_t pend; // Value waiting for cycle end
    logic pendValid; // Pending status write
    logic busy; // Write cycle running
    logic [31:0] wcnt; // Write cycle timer
    logic dataSeen; // Whole data byte received
    logic stDone; // Whole status byte received
    logic guardLowSeen; // Guard pin seen low this selection
    logic [7:0] wrByte; // Last data byte
    logic wrStrobe; // Data byte pulse
    logic writeGo; // Array cycle start pulse
  } state_t;

  state_t r_r; // Registered state
  state_t r_nxt; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Opcode match with bit 3 treated as don't-care
  function automatic logic opIs(input logic [7:0] code, input logic [7:0] op);
    opIs = ((code & spi_eeprom_pkg::OP_MASK) == op);
  endfunction

  // Address inside the read-only range chosen by the level bits
  function automatic logic isProtected(input logic [1:0] level, input logic [16:0] a);
    logic hit;
    hit = 1'b0;
    case (level)
      2'h0: hit = 1'b0; // Nothing protected [RULE_20]
      2'h1: hit = (a >= spi_eeprom_pkg::QUARTER_BASE); // Top quarter [RULE_20]
      2'h2: hit = (a >= spi_eeprom_pkg::HALF_BASE); // Top half [RULE_20]
      default: hit = 1'b1; // Whole array [RULE_20]
    endcase
    isProtected = hit;
  endfunction

  // Byte shown by a status read
  function automatic logic [7:0] statusByte(input logic bsy, input logic wel,
                                            input spi_eeprom_pkg::nv_status_t nv);
    logic [7:0] b;
    b = 8'h00; // Bits 6:4 stay zero when idle [RULE_18]
    b[spi_eeprom_pkg::STAT_BUSY_BIT] = bsy; // [RULE_16]
    b[spi_eeprom_pkg::STAT_LATCH_BIT] = wel; // [RULE_17]
    b[spi_eeprom_pkg::STAT_LEVEL_LO_BIT] = nv.level[0]; // [RULE_17]
    b[spi_eeprom_pkg::STAT_LEVEL_HI_BIT] = nv.level[1]; // [RULE_17]
    b[spi_eeprom_pkg::STAT_GUARD_BIT] = nv.guardEnable; // [RULE_17]
    if (bsy)
    begin
      b = spi_eeprom_pkg::STAT_BUSY_VALUE; // All ones mid-cycle [RULE_19]
    end
    statusByte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic sel;
    logic paused;
    logic sckRise;
    logic sckFall;
    logic csRise;
    logic hwGuard;
    logic [7:0] rxByte;
    logic [7:0] txByte;
    sel = 1'b0;
    paused = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    csRise = 1'b0;
    hwGuard = 1'b0;
    rxByte = 8'h00;
    txByte = 8'h00;
    r_nxt = r_r;
    r_nxt.writeGo = 1'b0;
    r_nxt.wrStrobe = 1'b0;

    // Pins cross into ref_clk through two flops; the first is read only here
    r_nxt.meta = '{csN: csN, sck: sck, si: si, holdN: holdN, guardN: guardN};
    r_nxt.sync = r_r.meta;
    r_nxt.sckPrev = r_r.sync.sck;
    r_nxt.csPrev = r_r.sync.csN;

    // Clock is only observed, never driven [RULE_01]
    sel = !r_r.sync.csN;
    paused = !r_r.sync.holdN;
    // Edges seen during a pause are dropped, prev keeps tracking [RULE_06] [RULE_07]
    sckRise = sel && !paused && r_r.sync.sck && !r_r.sckPrev;
    sckFall = sel && !paused && !r_r.sync.sck && r_r.sckPrev;
    csRise = r_r.sync.csN && !r_r.csPrev;
    rxByte = {r_r.rxShift[6:0], r_r.sync.si}; // MSB first in [RULE_02]

    // Guard pin counts only when guard enable is set [RULE_11]
    hwGuard = r_r.nv.guardEnable && (r_r.guardLowSeen || !r_r.sync.guardN);

    // Page pointer steps after each byte, high bits stay put
    if (r_r.wrStrobe)
    begin
      r_nxt.addr[6:0] = r_r.addr[6:0] + 7'h01;
    end

    // Self-timed write cycle; guard pin cannot reach it once started [RULE_10]
    if (r_r.busy)
    begin
      if (r_r.wcnt == 32'(WRITE_CYCLES - 1))
      begin
        r_nxt.busy = 1'b0;
        r_nxt.wcnt = 32'h00000000;
        r_nxt.latch = 1'b0; // Back to write disabled [RULE_25]
        if (r_r.pendValid)
        begin
          r_nxt.nv = r_r.pend; // Stored bits land at cycle end [RULE_21]
          r_nxt.pendValid = 1'b0;
        end
      end
      else
      begin
        r_nxt.wcnt = r_r.wcnt + 32'h00000001;
      end
    end

    // Any low guard level while selected arms the abort [RULE_10]
    if (sel && !r_r.sync.guardN)
    begin
      r_nxt.guardLowSeen = 1'b1;
    end

    if (!sel)
    begin
      // Deselected: parser waits for a new opcode, output off [RULE_05] [RULE_27]
      r_nxt.state = spi_eeprom_pkg::ST_OPCODE;
      r_nxt.bitCnt = 3'h0;
      r_nxt.addrCnt = 2'h0;
      r_nxt.txLive = 1'b0;
      r_nxt.dataSeen = 1'b0;
      r_nxt.stDone = 1'b0;
      r_nxt.guardLowSeen = 1'b0;
      if (csRise && !r_r.busy)
      begin
        // Array program needs latch and an unprotected page [RULE_14] [RULE_20] [RULE_22]
        if (r_r.state == spi_eeprom_pkg::ST_WRDATA && r_r.dataSeen && r_r.latch &&
            !isProtected(r_r.nv.level, r_r.addr))
        begin
          r_nxt.busy = 1'b1;
          r_nxt.wcnt = 32'h00000000;
          r_nxt.writeGo = 1'b1;
        end
        // Status program needs latch and no hardware guard [RULE_09] [RULE_21] [RULE_23]
        // Parser has already left the status-in state once the byte is whole
        if (r_r.stDone && r_r.latch && !hwGuard)
        begin
          r_nxt.busy = 1'b1;
          r_nxt.wcnt = 32'h00000000;
          r_nxt.pendValid = 1'b1;
        end
      end
    end
    else if (sckRise)
    begin
      // Data taken on the rising edge [RULE_26]
      r_nxt.rxShift = rxByte;
      r_nxt.bitCnt = r_r.bitCnt + 3'h1;
      if (r_r.bitCnt == 3'h7)
      begin
        case (r_r.state)
          spi_eeprom_pkg::ST_OPCODE:
          begin
            // Eighth bit completes the opcode [RULE_03]
            r_nxt.state = spi_eeprom_pkg::ST_IGNORE; // Unknown opcode [RULE_04]
            if (r_r.busy)
            begin
              // Mid-cycle only the status read gets through [RULE_24]
              if (opIs(rxByte, spi_eeprom_pkg::OP_STATUS_READ))
              begin
                r_nxt.state = spi_eeprom_pkg::ST_STATUS_OUT;
              end
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_LATCH_SET))
            begin
              r_nxt.latch = 1'b1; // [RULE_12] [RULE_14]
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_LATCH_CLEAR))
            begin
              r_nxt.latch = 1'b0; // Guard pin plays no part [RULE_12] [RULE_15]
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_STATUS_READ))
            begin
              r_nxt.state = spi_eeprom_pkg::ST_STATUS_OUT; // [RULE_12]
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_STATUS_WRITE))
            begin
              r_nxt.state = spi_eeprom_pkg::ST_STATUS_IN; // [RULE_13]
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_ARRAY_READ))
            begin
              r_nxt.state = spi_eeprom_pkg::ST_ADDR; // [RULE_13]
              r_nxt.isWrite = 1'b0;
            end
            else if (opIs(rxByte, spi_eeprom_pkg::OP_ARRAY_WRITE))
            begin
              r_nxt.state = spi_eeprom_pkg::ST_ADDR; // [RULE_13]
              r_nxt.isWrite = 1'b1;
            end
          end
          spi_eeprom_pkg::ST_ADDR:
          begin
            // Three bytes, MSB first; top seven bits fall off [RULE_02]
            r_nxt.addr = {r_r.addr[8:0], rxByte};
            r_nxt.addrCnt = r_r.addrCnt + 2'h1;
            if (r_r.addrCnt == spi_eeprom_pkg::ADDR_LAST_BYTE)
            begin
              r_nxt.state = r_r.isWrite ? spi_eeprom_pkg::ST_WRDATA : spi_eeprom_pkg::ST_DATA_OUT;
            end
          end
          spi_eeprom_pkg::ST_WRDATA:
          begin
            // Bytes are handed out; the page buffer lives outside
            r_nxt.wrByte = rxByte;
            r_nxt.wrStrobe = 1'b1;
            r_nxt.dataSeen = 1'b1;
          end
          spi_eeprom_pkg::ST_STATUS_IN:
          begin
            // Only the stored bits are taken; extra bytes are ignored
            r_nxt.pend.guardEnable = rxByte[spi_eeprom_pkg::STAT_GUARD_BIT];
            r_nxt.pend.level = {rxByte[spi_eeprom_pkg::STAT_LEVEL_HI_BIT],
                                rxByte[spi_eeprom_pkg::STAT_LEVEL_LO_BIT]};
            r_nxt.stDone = 1'b1;
            r_nxt.state = spi_eeprom_pkg::ST_IGNORE;
          end
          default:
          begin
            // Output and ignore phases drop incoming bytes [RULE_04]
            r_nxt.state = r_r.state;
          end
        endcase
      end
    end
    else if (sckFall)
    begin
      // Output changes on the falling edge [RULE_26]
      if ((r_r.state == spi_eeprom_pkg::ST_STATUS_OUT || r_r.state == spi_eeprom_pkg::ST_DATA_OUT) &&
          r_r.bitCnt == 3'h0)
      begin
        if (r_r.state == spi_eeprom_pkg::ST_STATUS_OUT)
        begin
          txByte = statusByte(r_r.busy, r_r.latch, r_r.nv); // Re-read every byte
        end
        else
        begin
          txByte = arrayRdData;
          r_nxt.addr = r_r.addr + 17'h00001; // Whole-array roll-over
        end
        r_nxt.soOut = txByte[7]; // MSB first out [RULE_02]
        r_nxt.txShift = {txByte[6:0], 1'b0};
        r_nxt.txLive = 1'b1;
      end
      else if (r_r.txLive)
      begin
        r_nxt.soOut = r_r.txShift[7]; // [RULE_02]
        r_nxt.txShift = {r_r.txShift[6:0], 1'b0};
      end
    end

    // Drive only while selected, not paused, with a byte under way [RULE_05] [RULE_08]
    r_nxt.soOe = sel && !paused && r_nxt.txLive;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      r_r <= '0;
      r_r.meta <= spi_eeprom_pkg::PINS_IDLE; // Look deselected after reset
      r_r.sync <= spi_eeprom_pkg::PINS_IDLE;
      r_r.sckPrev <= 1'b0;
      r_r.csPrev <= 1'b1;
      r_r.nv <= spi_eeprom_pkg::NV_RESET;
      r_r.latch <= 1'b0; // Write disabled at start [RULE_14]
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops
  assign soOut = r_r.soOut;
  assign soOe = r_r.soOe;
  assign busy = r_r.busy;
  assign writeLatch = r_r.latch;
  assign arrayAddr = r_r.addr;
  assign arrayWrData = r_r.wrByte;
  assign arrayWrStrobe = r_r.wrStrobe;
  assign arrayWriteGo = r_r.writeGo;

endmodule

// ---- bench/spi_eeprom_command_protect_asserts.sv ----
`timescale 1ns/1ps
module spi_eeprom_cp_checker #(
  parameter int WRITE_CYCLES = 50 // Write cycle length in core cycles
)(
  input wire logic ref_clk, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic csN, // Chip select pin
  input wire logic holdN, // Pause pin
  input wire logic soOut, // Serial out level
  input wire logic soOe, // Serial out enable
  input wire logic busy, // Write cycle running
  input wire logic writeLatch, // Write enable latch
  input wire logic arrayWrStrobe, // Byte strobe
  input wire logic arrayWriteGo // Write start pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  int busyCnt_r; // Cycles the write cycle has stood so far
  // Count busy cycles; cleared when idle so each cycle is measured alone
  always_ff @(posedge ref_clk)
  begin
    if (srst || !busy)
      busyCnt_r <= 0;
    else
      busyCnt_r <= busyCnt_r + 1;
  end
  ////////////////////////////////////////
  // Sync delay is three cycles, so five quiet cycles settle the output
  sequence deselS;
    csN [*5];
  endsequence
  sequence pausedS;
    (!holdN) [*5];
  endsequence
  a_desel_out_off: assert property (deselS |-> !soOe)
    else $error("serial output driven while deselected");
  a_pause_out_off: assert property (pausedS |-> !soOe)
    else $error("serial output driven while paused");
  a_busy_all_ones: assert property (busy && soOe |-> soOut)
    else $error("status bit not one during write cycle");
  a_start_needs_latch: assert property ($rose(busy) |-> writeLatch)
    else $error("write cycle started without latch");
  a_go_then_busy: assert property (arrayWriteGo |-> writeLatch ##[0:2] busy)
    else $error("array write start not followed by busy");
  a_end_clears_latch: assert property ($fell(busy) |-> ##[0:1] !writeLatch)
    else $error("latch still set after write cycle");
  // Reset may cut a cycle short, so only natural ends are timed
  a_cycle_length: assert property ($fell(busy) && !$past(srst) |->
    busyCnt_r >= WRITE_CYCLES - 2 && busyCnt_r <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  a_busy_quiet: assert property (busy && $past(busy) |-> !arrayWrStrobe && !arrayWriteGo)
    else $error("array activity during write cycle");
  a_latch_idle_only: assert property ($rose(writeLatch) |-> !busy)
    else $error("latch set during write cycle");
endmodule
bind spi_eeprom_command_protect spi_eeprom_cp_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
  .ref_clk(ref_clk), .srst(srst), .csN(csN), .holdN(holdN), .soOut(soOut), .soOe(soOe),
  .busy(busy), .writeLatch(writeLatch), .arrayWrStrobe(arrayWrStrobe), .arrayWriteGo(arrayWriteGo));

// ---- bench/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model (
  input wire logic ref_clk, // Core clock paces the link
  output logic csN, // Chip select
  output logic sck, // Serial clock, idle low
  output logic si, // Serial data to device
  output logic holdN, // Pause request
  input wire logic soOut, // Serial data from device
  input wire logic soOe // Device output enable
);
  localparam int HALF = 4; // 80 ns half period of the link clock
  logic anyOe; // Device drove its output during this frame
  initial
  begin
    csN = 1'b1;
    sck = 1'b0;
    si = 1'b1;
    holdN = 1'b1;
    anyOe = 1'b0;
  end
  ////////////////////////////////////////
  // Move just after an edge so the device never sees a same-step change
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic sel();
    tick(1);
    csN = 1'b0;
    anyOe = 1'b0;
    tick(6);
  endtask
  task automatic desel();
    tick(HALF);
    csN = 1'b1;
    si = ~si; // Idle data line never repeats its last bit
    tick(8);
  endtask
  // Pause only with the clock low; clock and data wiggle while paused
  task automatic pause();
    // Let the clock fall settle first so pause never masks that edge
    tick(HALF);
    holdN = 1'b0;
    tick(HALF);
    repeat (3)
    begin
      sck = 1'b1;
      si = ~si;
      tick(HALF);
      sck = 1'b0;
      tick(HALF);
    end
    holdN = 1'b1;
    tick(HALF);
  endtask
  // One byte each way, MSB first; a disabled output reads as unknown
  task automatic xb(input logic [7:0] tx, input int holdAt, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == holdAt)
        pause();
      si = tx[i];
      tick(HALF);
      rx[i] = soOe ? soOut : 1'bx;
      anyOe = anyOe | soOe;
      sck = 1'b1;
      tick(HALF);
      sck = 1'b0;
    end
  endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  localparam int WCYC = 400; // Shortened, yet long enough to read status mid-cycle
  logic ref_clk = 1'b0; // Core clock
  logic srst = 1'b1; // Reset
  logic guardN = 1'b1; // Write-guard pin
  logic csN, sck, si, holdN, soOut, soOe, busy, writeLatch, arrayWrStrobe, arrayWriteGo;
  logic [16:0] arrayAddr; // Array pointer
  logic [7:0] arrayWrData, arrayRdData, s, d;
  logic g; // Expected guard enable
  logic [1:0] lv; // Expected protect level
  int badCount = 0;
  int totalChecks = 0;
  int seed = 70072;
  int goCount = 0;
  always #10 ref_clk = ~ref_clk;
  assign arrayRdData = arrayAddr[7:0] ^ 8'hA5; // Array contents follow address
  spi_eeprom_command_protect #(.WRITE_CYCLES(WCYC)) dut (.ref_clk(ref_clk), .srst(srst), .csN(csN),
    .sck(sck), .si(si), .holdN(holdN), .guardN(guardN), .soOut(soOut), .soOe(soOe), .busy(busy),
    .writeLatch(writeLatch), .arrayAddr(arrayAddr), .arrayRdData(arrayRdData),
    .arrayWrData(arrayWrData), .arrayWrStrobe(arrayWrStrobe), .arrayWriteGo(arrayWriteGo));
  spi_master_model mst (.ref_clk(ref_clk), .csN(csN), .sck(sck), .si(si), .holdN(holdN),
    .soOut(soOut), .soOe(soOe));
  // Count write starts seen at the port
  always @(posedge ref_clk)
    if (arrayWriteGo === 1'b1)
      goCount++;
  logic [7:0] wrSeen; // Data byte seen at the last strobe
  logic [16:0] wrAt; // Address seen at the last strobe
  // Capture what the write strobe hands over
  always @(posedge ref_clk)
    if (arrayWrStrobe === 1'b1)
    begin
      wrSeen = arrayWrData;
      wrAt = arrayAddr;
    end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    totalChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Instruction with a random don't-care bit 3
  function automatic logic [7:0] op(input logic [7:0] b);
    return b | (8'($random(seed)) & 8'h08);
  endfunction
  function automatic logic [7:0] stat(input logic ge, input logic [1:0] l, input logic wl);
    return {ge, 3'h0, l, wl, 1'b0};
  endfunction
  function automatic logic prot(input logic [1:0] l, input logic [16:0] a);
    return (l == 2'h3) || (l == 2'h2 && a >= 17'h10000) || (l == 2'h1 && a >= 17'h18000);
  endfunction
  // Opcode, optional three address bytes, one data byte; drop pulses the guard low
  task automatic frame(input logic [7:0] o, input logic [16:0] a, input logic [7:0] v,
    input bit adr, input bit drop, output logic [7:0] r);
    logic g0;
    g0 = guardN;
    mst.sel();
    mst.xb(o, 8, r);
    if (adr)
    begin
      mst.xb({7'h00, a[16]}, 8, r);
      mst.xb(a[15:8], 8, r);
      mst.xb(a[7:0], 8, r);
    end
    if (drop)
      guardN = 1'b0;
    mst.xb(v, 8, r);
    guardN = g0;
    mst.desel();
  endtask
  task automatic sts(input int h, input logic [7:0] exp);
    mst.sel();
    mst.xb(op(8'h05), h, s);
    mst.xb(8'h00, h, s);
    mst.desel();
    chk("status", exp, s);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < WCYC + 400 && busy !== 1'b0; i++)
      @(posedge ref_clk);
    chk("busy", 17'h0, busy);
  endtask
  task automatic aw(input logic [16:0] a);
    int n;
    n = goCount;
    wrSeen = 8'h00;
    wrAt = 17'h00000;
    frame(op(8'h06), 17'h0, 8'h00, 0, 0, s);
    frame(op(8'h02), a, 8'h5A, 1, 0, s);
    mst.tick(4);
    chk("go", prot(lv, a) ? 17'h0 : 17'h1, 17'(goCount - n));
    chk("wrdata", 17'h5A, wrSeen);
    chk("wraddr", a, wrAt);
    waitIdle();
    frame(op(8'h04), 17'h0, 8'h00, 0, 0, s);
    chk("latch", 17'h0, writeLatch);
  endtask
  task automatic setStat(input logic [7:0] v, input bit drop, input bit ok);
    frame(op(8'h06), 17'h0, 8'h00, 0, 0, s);
    frame(op(8'h01), 17'h0, v, 0, drop, s);
    if (ok)
      sts(8, 8'hFF);
    waitIdle();
    sts(8, stat(g, lv, !ok));
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  // Whole run is near 17k cycles; the 75k-cycle limit, over four times that, means a hang
  initial
  begin
    #1_500_000;
    badCount++;
    finishTest();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    mst.tick(4);
    g = 1'b0;
    lv = 2'h0;
    sts(8, stat(0, 0, 0));
    frame(op(8'h01), 17'h0, 8'h8C, 0, 0, s);
    sts(3, stat(0, 0, 0));
    frame(8'h10 | 8'($random(seed)), 17'($random(seed)), 8'h05, 1, 0, s);
    chk("oe", 17'h0, mst.anyOe);
    frame(op(8'h03), 17'h0ABCD, 8'h00, 1, 0, d);
    chk("read", 17'h0CD ^ 17'hA5, d);
    for (int l = 0; l < 4; l++)
    begin
      frame(op(8'h06), 17'h0, 8'h00, 0, 0, s);
      sts(8, stat(g, lv, 1));
      lv = 2'(l);
      setStat({1'b0, 3'($random(seed)), 2'(l), 2'($random(seed))}, 0, 1);
      aw(l[0] ? 17'h18000 : 17'h0FFFF);
      aw(17'($random(seed)));
    end
    guardN = 1'b0;
    g = 1'b1;
    lv = 2'h1;
    setStat(8'h84, 0, 1);
    setStat(8'h00, 0, 0);
    aw(17'h00100);
    aw(17'h18000);
    guardN = 1'b1;
    setStat(8'h00, 1, 0);
    g = 1'b0;
    lv = 2'h0;
    setStat(8'h00, 0, 1);
    finishTest();
  end
endmodule
